//--- hw/aec_regs.svh
// Constants for the attitude error counter block.
`ifndef AEC_REGS_SVH
`define AEC_REGS_SVH

// ****************************************************************
// Clock and carrier timing
// ****************************************************************
`define AEC_CLK_FREQ_HZ 40000000
`define AEC_CARRIER_FREQ_HZ 800
`define AEC_CARRIER_HALF_CYCLES (`AEC_CLK_FREQ_HZ / (2 * `AEC_CARRIER_FREQ_HZ))

// ****************************************************************
// Pulse scaling in tenths of an arc second
// ****************************************************************
`define AEC_SCALE_NORMAL_DASEC 1582
`define AEC_SCALE_ROLL_BOOST_DASEC 6328
// The roll boost weight is four normal counts, a left shift of two.
`define AEC_ROLL_SHIFT 2

// ****************************************************************
// Axis layout and defaults
// ****************************************************************
`define AEC_AXIS_ROLL 0
`define AEC_ERR_WIDTH 9
`define AEC_READ_WIDTH 16
`define AEC_NUM_OTHER 4

`endif

//--- hw/aec_pkg.sv
// Types shared by the attitude error counter block.
`default_nettype none

package aec_pkg;

    localparam int NUM_AXES = 3;

    // Mode codes follow a Gray path: inertial, display, attitude control, slew.
    typedef enum logic [1:0] {
        AEC_MODE_INERTIAL = 2'h0,
        AEC_MODE_DISPLAY = 2'h1,
        AEC_MODE_ATT_CTL = 2'h3,
        AEC_MODE_SLEW = 2'h2
    } aec_mode_t;

    // One up and one down pulse line per axis.
    typedef struct packed {
        logic [NUM_AXES-1:0] up;
        logic [NUM_AXES-1:0] down;
    } aec_pulse_t;

endpackage

`default_nettype wire

//--- hw/aec_sync.sv
// Two-stage synchroniser with a rising edge detector behind it.
`default_nettype none

module aec_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_sync_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] prev_reg;

    // The first stage feeds only the second; edges are taken after it.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meta_reg <= '0;
            stable_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= din;
            stable_reg <= meta_reg;
            prev_reg <= stable_reg;
        end
    end

    assign level = stable_reg;
    assign rise = stable_reg & ~prev_reg;

endmodule

`default_nettype wire

//--- hw/aec_top.sv
// Attitude error counters, read counters and carrier ladder output.
//
// Notes on behaviour
// [RULE_01] Counter enable alone, no other mode discrete, selects attitude error display mode.
// [RULE_02] Display mode enables error counters; read counters keep forwarding attitude increments.
// [RULE_03] Computer bursts error pulses at 3200 pps, 158.2 arc seconds each.
// [RULE_04] Roll axis during boost monitor and entry weighs 632.8 arc seconds per pulse.
// [RULE_05] Each error counter is continuously converted to an indicator drive signal.
// [RULE_06] Display mode blocks read counter feedback; only computer pulses move error counters.
// [RULE_07] Autopilot attitude control keeps error counters enabled for computer pulses.
// [RULE_08] Computer loads counters with the desired gimbal angle change per axis.
// [RULE_09] Conversion goes through a ladder referenced to an 800 cps carrier.
// [RULE_10] Gimbal increments from mixing logic enter read counters and go to the computer.
// [RULE_11] After a maneuver the computer pulses error counters back to zero.
// [RULE_12] With no moding command the error counters stay cleared and inhibited.
// [RULE_13] Error counters are signed up/down, one count per pulse.
`include "aec_regs.svh"
`default_nettype none

module aec_top #(
    parameter int ERR_W = `AEC_ERR_WIDTH,
    parameter int READ_W = `AEC_READ_WIDTH,
    parameter int NUM_OTHER = `AEC_NUM_OTHER,
    parameter int CARRIER_HALF = `AEC_CARRIER_HALF_CYCLES,
    localparam int OUT_W = ERR_W + `AEC_ROLL_SHIFT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cnt_enable_in,
    input wire logic [NUM_OTHER-1:0] other_mode_in,
    input wire logic att_ctl_in,
    input wire logic roll_boost_in,
    input wire aec_pkg::aec_pulse_t err_pulse_in,
    input wire aec_pkg::aec_pulse_t gimbal_pulse_in,
    output aec_pkg::aec_pulse_t angle_pulse_out,
    output logic [aec_pkg::NUM_AXES-1:0][READ_W-1:0] read_count_out,
    output logic [aec_pkg::NUM_AXES-1:0][ERR_W-1:0] err_count_out,
    output logic [aec_pkg::NUM_AXES-1:0][OUT_W-1:0] ladder_word,
    output logic carrier_phase,
    output aec_pkg::aec_mode_t mode_out
);

    localparam int NA = aec_pkg::NUM_AXES;
    localparam int DW = NUM_OTHER + 3;
    localparam logic signed [ERR_W-1:0] ERR_MAX = {1'h0, {(ERR_W-1){1'h1}}};
    localparam logic [15:0] HALF_LAST = 16'(CARRIER_HALF - 1);

    // ****************************************************************
    // Reset release and input synchronisers
    // ****************************************************************
    logic rst_meta_reg;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'h0;
            rst_sync_n <= 1'h0;
        end else begin
            rst_meta_reg <= 1'h1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    logic [DW-1:0] disc_level;
    aec_pkg::aec_pulse_t err_rise;
    aec_pkg::aec_pulse_t gim_rise;

    aec_sync #(.WIDTH(DW)) u_disc_sync (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_n),
        .din({roll_boost_in, att_ctl_in, cnt_enable_in, other_mode_in}),
        .level(disc_level),
        .rise()
    );

    // Pulses are counted on their rising edge, so a wide pulse counts once.
    aec_sync #(.WIDTH(2 * NA)) u_err_sync (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_n),
        .din(err_pulse_in),
        .level(),
        .rise(err_rise)
    );

    aec_sync #(.WIDTH(2 * NA)) u_gim_sync (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_n),
        .din(gimbal_pulse_in),
        .level(),
        .rise(gim_rise)
    );

    logic other_any;
    logic cnt_en_s;
    logic att_ctl_s;
    logic roll_boost_s;

    assign other_any = |disc_level[NUM_OTHER-1:0];
    assign cnt_en_s = disc_level[NUM_OTHER];
    assign att_ctl_s = disc_level[NUM_OTHER+1];
    assign roll_boost_s = disc_level[NUM_OTHER+2];

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    aec_pkg::aec_mode_t mode_reg;
    aec_pkg::aec_mode_t mode_next;

    always_comb begin
        mode_next = aec_pkg::AEC_MODE_INERTIAL; // RULE_12
        if (cnt_en_s && other_any) begin
            mode_next = aec_pkg::AEC_MODE_SLEW;
        end else if (cnt_en_s) begin
            mode_next = aec_pkg::AEC_MODE_DISPLAY; // RULE_01
        end else if (att_ctl_s) begin
            mode_next = aec_pkg::AEC_MODE_ATT_CTL; // RULE_07
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_reg <= aec_pkg::AEC_MODE_INERTIAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign mode_out = mode_reg;

    // ****************************************************************
    // Error counters and read counters
    // ****************************************************************
    logic signed [NA-1:0][ERR_W-1:0] err_reg;
    logic signed [NA-1:0][ERR_W-1:0] err_next;
    logic [NA-1:0][READ_W-1:0] rd_reg;
    logic [NA-1:0][READ_W-1:0] rd_next;
    aec_pkg::aec_pulse_t fwd_reg;
    logic fb_on;
    logic cnt_on;

    // Feedback only runs while slewing; saturation keeps negation safe.
    assign fb_on = (mode_next == aec_pkg::AEC_MODE_SLEW);
    assign cnt_on = (mode_next != aec_pkg::AEC_MODE_INERTIAL); // RULE_02 RULE_07

    always_comb begin
        logic signed [2:0] step;
        logic signed [ERR_W+1:0] sum;
        step = '0;
        sum = '0;
        for (int a = 0; a < NA; a++) begin
            step = 3'($signed({2'h0, err_rise.up[a]})) - 3'($signed({2'h0, err_rise.down[a]}));
            if (fb_on) begin // RULE_06
                step = step - 3'($signed({2'h0, gim_rise.up[a]}))
                    + 3'($signed({2'h0, gim_rise.down[a]}));
            end
            sum = (ERR_W+2)'($signed(err_reg[a])) + (ERR_W+2)'(step); // RULE_13
            if (!cnt_on) begin
                err_next[a] = '0; // RULE_12
            end else if (sum > (ERR_W+2)'(ERR_MAX)) begin
                err_next[a] = ERR_MAX;
            end else if (sum < -(ERR_W+2)'(ERR_MAX)) begin
                err_next[a] = -ERR_MAX;
            end else begin
                err_next[a] = ERR_W'(sum);
            end
            rd_next[a] = rd_reg[a] + READ_W'(gim_rise.up[a]) - READ_W'(gim_rise.down[a]); // RULE_10
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            err_reg <= '0;
            rd_reg <= '0;
            fwd_reg <= '0;
        end else begin
            err_reg <= err_next;
            rd_reg <= rd_next;
            fwd_reg <= gim_rise; // RULE_10 RULE_02
        end
    end

    assign err_count_out = err_reg;
    assign read_count_out = rd_reg;
    assign angle_pulse_out = fwd_reg;

    // ****************************************************************
    // Carrier divider and ladder output
    // ****************************************************************
    logic [15:0] car_cnt_reg;
    logic [15:0] car_cnt_next;
    logic phase_reg;
    logic phase_next;
    logic [NA-1:0][OUT_W-1:0] ladder_reg;
    logic [NA-1:0][OUT_W-1:0] ladder_next;

    always_comb begin
        logic signed [OUT_W-1:0] val;
        val = '0;
        car_cnt_next = car_cnt_reg + 16'h0001;
        phase_next = phase_reg;
        if (car_cnt_reg == HALF_LAST) begin // RULE_09
            car_cnt_next = 16'h0000;
            phase_next = ~phase_reg;
        end
        for (int a = 0; a < NA; a++) begin
            val = OUT_W'($signed(err_reg[a])); // RULE_05
            if (a == `AEC_AXIS_ROLL && roll_boost_s) begin
                val = val <<< `AEC_ROLL_SHIFT; // RULE_04
            end
            // The pi phase half of the carrier drives the inverted word.
            ladder_next[a] = phase_reg ? OUT_W'(-val) : OUT_W'(val); // RULE_09
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            car_cnt_reg <= 16'h0000;
            phase_reg <= 1'h0;
            ladder_reg <= '0;
        end else begin
            car_cnt_reg <= car_cnt_next;
            phase_reg <= phase_next;
            ladder_reg <= ladder_next;
        end
    end

    assign ladder_word = ladder_reg;
    assign carrier_phase = phase_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic signed [ERR_W-1:0] err0;
    logic signed [ERR_W-1:0] err1;
    logic signed [ERR_W-1:0] err2;
    assign err0 = err_reg[0];
    assign err1 = err_reg[1];
    assign err2 = err_reg[2];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    a_inertial_clear: assert property ( // RULE_12
            mode_reg == aec_pkg::AEC_MODE_INERTIAL |-> err_reg == '0)
        else $error("Error counters not cleared in inertial mode.");
    a_display_entry: assert property ( // RULE_01
            cnt_en_s && !other_any |=> mode_reg == aec_pkg::AEC_MODE_DISPLAY)
        else $error("Display mode not entered.");
    a_count_up: assert property ( // RULE_13
            mode_next == aec_pkg::AEC_MODE_DISPLAY && err_rise.up[0] && !err_rise.down[0]
            && err0 < ERR_MAX |=> err0 == $past(err0) + 1)
        else $error("Error counter missed an up pulse.");
    a_no_feedback: assert property ( // RULE_06
            mode_next == aec_pkg::AEC_MODE_DISPLAY && !err_rise.up[1] && !err_rise.down[1]
            && gim_rise.up[1] |=> err1 == $past(err1))
        else $error("Feedback moved the error counter in display mode.");
    a_att_ctl_count: assert property ( // RULE_07
            mode_next == aec_pkg::AEC_MODE_ATT_CTL && err_rise.up[2] && !err_rise.down[2]
            && err2 < ERR_MAX |=> err2 == $past(err2) + 1)
        else $error("Error counter disabled during attitude control.");
    a_fwd_pulse: assert property ( // RULE_10
            gim_rise.up[1] && !gim_rise.down[1] |=> angle_pulse_out.up[1]
            && read_count_out[1] == READ_W'($past(read_count_out[1]) + 1))
        else $error("Gimbal increment not forwarded.");
    a_ladder_track: assert property ( // RULE_05
            !phase_reg |=> ladder_word[2] == OUT_W'($past(err2)))
        else $error("Ladder word does not follow the error counter.");
    a_roll_scale: assert property ( // RULE_04
            roll_boost_s && !phase_reg
            |=> $signed(ladder_word[0]) == ($signed(OUT_W'($past(err0))) <<< `AEC_ROLL_SHIFT))
        else $error("Roll boost scaling wrong.");
    a_carrier_half: assert property ( // RULE_09
            $changed(phase_reg) |-> $past(car_cnt_reg) == HALF_LAST)
        else $error("Carrier toggled off its half period.");

    c_display: cover property (mode_reg == aec_pkg::AEC_MODE_DISPLAY && err0 != '0);
    c_att_ctl: cover property (mode_reg == aec_pkg::AEC_MODE_ATT_CTL ##1 err2 != '0);
    c_slew_null: cover property (mode_reg == aec_pkg::AEC_MODE_SLEW && gim_rise.up[0]);
    c_roll_boost: cover property (roll_boost_s && err0 != '0 && phase_reg);

endmodule

`default_nettype wire

//--- tb/aec_computer_model.sv
// Behavioural model of the guidance computer driving mode discretes and error pulses.
`default_nettype none

module aec_computer_model #(
    parameter int NUM_OTHER = 4
) (
    input wire logic ref_clk,
    output logic cnt_enable,
    output logic [NUM_OTHER-1:0] other_mode,
    output logic att_ctl,
    output logic roll_boost,
    output aec_pkg::aec_pulse_t err_pulse
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cnt_enable = 1'h0;
        other_mode = '0;
        att_ctl = 1'h0;
        roll_boost = 1'h0;
        err_pulse = '0;
    end

    // ****************************************************************
    // Mode discretes
    // ****************************************************************
    task automatic set_mode(input logic ce, input logic [NUM_OTHER-1:0] om,
                            input logic ac, input logic rb);
        @(negedge ref_clk);
        cnt_enable = ce;
        other_mode = om;
        att_ctl = ac;
        roll_boost = rb;
    endtask

    // ****************************************************************
    // Error pulse bursts
    // ****************************************************************
    // The pulse rate is far above the real one so runs stay short.
    task automatic burst(input int ax, input bit up, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            if (up) begin
                err_pulse.up[ax] = 1'h1;
            end else begin
                err_pulse.down[ax] = 1'h1;
            end
            repeat (4) @(negedge ref_clk);
            err_pulse = '0;
            repeat (3) @(negedge ref_clk);
        end
    endtask
endmodule

`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the attitude error counter block.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk;
    logic rst_n;
    logic cnt_en;
    logic [3:0] other;
    logic att;
    logic rboost;
    aec_pkg::aec_pulse_t errp;
    aec_pkg::aec_pulse_t gim;
    aec_pkg::aec_pulse_t ang;
    logic [aec_pkg::NUM_AXES-1:0][15:0] rd;
    logic [aec_pkg::NUM_AXES-1:0][8:0] err;
    logic [aec_pkg::NUM_AXES-1:0][10:0] lad;
    logic carrier;
    aec_pkg::aec_mode_t mode;
    int n_fail;
    int num_checks;
    int cycles;

    aec_computer_model #(.NUM_OTHER(4)) computer (.ref_clk(ref_clk), .cnt_enable(cnt_en),
        .other_mode(other), .att_ctl(att), .roll_boost(rboost), .err_pulse(errp));

    // A short carrier half period keeps the run small.
    aec_top #(.CARRIER_HALF(8)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cnt_enable_in(cnt_en),
        .other_mode_in(other), .att_ctl_in(att), .roll_boost_in(rboost),
        .err_pulse_in(errp), .gimbal_pulse_in(gim), .angle_pulse_out(ang),
        .read_count_out(rd), .err_count_out(err), .ladder_word(lad),
        .carrier_phase(carrier), .mode_out(mode));

    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    initial ref_clk = 1'h0;
    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic gimbal(input int ax, input bit up);
        int seen;
        seen = 0;
        if (up) begin
            gim.up[ax] = 1'h1;
        end else begin
            gim.down[ax] = 1'h1;
        end
        for (int i = 0; i < 8; i++) begin
            if (i == 4) begin
                gim = '0;
            end
            cyc(1);
            if ((up ? ang.up[ax] : ang.down[ax]) === 1'h1) begin
                seen++;
            end
        end
        chk(seen, 16'h0001);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_display;
        computer.set_mode(1'h1, 4'h0, 1'h0, 1'h0);
        cyc(5);
        chk(mode, aec_pkg::AEC_MODE_DISPLAY);
        computer.burst(1, 1'h1, 5);
        cyc(3);
        chk(err[1], 16'h0005);
        gimbal(1, 1'h1);
        chk(rd[1], 16'h0001);
        chk(err[1], 16'h0005);
        computer.burst(1, 1'h0, 5);
        cyc(3);
        chk(err[1], 16'h0000);
    endtask

    task automatic t_attctl;
        computer.set_mode(1'h0, 4'h0, 1'h1, 1'h0);
        cyc(5);
        chk(mode, aec_pkg::AEC_MODE_ATT_CTL);
        computer.burst(2, 1'h1, 4);
        cyc(3);
        chk(err[2], 16'h0004);
        gimbal(2, 1'h0);
        chk(rd[2], 16'hFFFF);
    endtask

    task automatic t_ladder;
        logic ph;
        int n;
        computer.set_mode(1'h1, 4'h0, 1'h0, 1'h1);
        computer.burst(0, 1'h1, 3);
        computer.burst(1, 1'h1, 2);
        cyc(3);
        ph = carrier;
        n = 0;
        while (carrier === ph && n < 40) begin
            cyc(1);
            n++;
        end
        ph = carrier;
        n = 0;
        while (carrier === ph && n < 40) begin
            cyc(1);
            n++;
            if (n == 2) begin
                chk(lad[0], ph ? 16'h07F4 : 16'h000C);
                chk(lad[1], ph ? 16'h07FE : 16'h0002);
            end
        end
        chk(n, 16'h0008);
    endtask

    task automatic t_slew_inertial;
        computer.set_mode(1'h1, 4'h2, 1'h0, 1'h0);
        cyc(5);
        chk(mode, aec_pkg::AEC_MODE_SLEW);
        gimbal(0, 1'h1);
        chk(err[0], 16'h0002);
        chk(rd[0], 16'h0001);
        computer.set_mode(1'h0, 4'h0, 1'h0, 1'h0);
        cyc(5);
        chk(mode, aec_pkg::AEC_MODE_INERTIAL);
        chk(err[0], 16'h0000);
        computer.burst(2, 1'h1, 2);
        cyc(3);
        chk(err[2], 16'h0000);
        gimbal(0, 1'h1);
        chk(rd[0], 16'h0002);
    endtask

    initial begin
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        rst_n = 1'h0;
        gim = '0;
        cyc(20);
        rst_n = 1'h1;
        cyc(6);
        chk(mode, aec_pkg::AEC_MODE_INERTIAL);
        chk(err[2], 16'h0000);
        t_display();
        t_attctl();
        t_ladder();
        t_slew_inertial();
        complete_run();
    end
endmodule

`default_nettype wire
